// file: src/frontend_pkg.sv
package frontend_pkg;
   // ==========================================================
   // widths and cache geometry
   localparam int XLEN = 32;
   localparam int CACHE_BYTES = 512;
   localparam int WORD_BYTES = 4;
   localparam int CACHE_WORDS = CACHE_BYTES / WORD_BYTES;
   localparam int IDX_W = $clog2(CACHE_WORDS);
   localparam int IDX_LSB = 2;
   localparam int TAG_LSB = IDX_LSB + IDX_W;
   localparam int TAG_W = XLEN - TAG_LSB;
   localparam logic [XLEN-1:0] RESET_IP = 32'h0000_0000;
   localparam logic [XLEN-1:0] IP_STEP = 32'h0000_0004;

   // ==========================================================
   // instruction word fields
   localparam int OP_MSB = 31;
   localparam int OP_LSB = 24;
   localparam int COND_W = 3;
   localparam int DISP_MSB = 23;
   localparam int DISP_W = 24;
   localparam int DISP_SHIFT = 2;
   localparam int EA_IPREL_BIT = 15;
   localparam int LAT_MSB = 14;
   localparam int LAT_LSB = 12;
   localparam int OFS_MSB = 11;
   localparam int OFS_W = 12;
   localparam logic [2:0] EA_MAX_CYC = 3'h4;

   // ==========================================================
   // opcode classes
   localparam logic [4:0] CLS_BR = 5'h01;
   localparam logic [4:0] CLS_CBR = 5'h02;
   localparam logic [4:0] CLS_CFLT = 5'h03;
   localparam logic [3:0] NIB_COMPLEX = 4'h6;
   localparam logic [3:0] NIB_FLOAT = 4'h7;
   localparam logic [3:0] NIB_LDST_LO = 4'h8;
   localparam logic [3:0] NIB_LDST_HI = 4'hC;

   typedef logic [7:0] opcode_t;
   typedef enum logic [3:0] {
      GRP_SIMPLE = 4'h1, GRP_FPBR = 4'h2, GRP_COMPLEX = 4'h4, GRP_LDST = 4'h8
   } group_e;
   typedef enum logic [3:0] {
      KIND_NONE = 4'h1, KIND_BR = 4'h2, KIND_CBR = 4'h4, KIND_CFLT = 4'h8
   } kind_e;
   typedef enum logic [3:0] {
      F_PROBE = 4'h1, F_CHECK = 4'h2, F_REQ = 4'h4, F_WAIT = 4'h8
   } fetch_e;

   // branch-type decoding
   function automatic kind_e kind_of(input opcode_t op);
      case (op[7:3])
         CLS_BR: kind_of = KIND_BR;
         CLS_CBR: kind_of = KIND_CBR;
         CLS_CFLT: kind_of = KIND_CFLT;
         default: kind_of = KIND_NONE;
      endcase
   endfunction

   // execution group decoding
   function automatic group_e group_of(input opcode_t op);
      if (kind_of(op) != KIND_NONE || op[7:4] == NIB_FLOAT) begin
         group_of = GRP_FPBR;
      end else if (op[7:4] == NIB_COMPLEX) begin
         group_of = GRP_COMPLEX;
      end else if (op[7:4] >= NIB_LDST_LO && op[7:4] <= NIB_LDST_HI) begin
         group_of = GRP_LDST;
      end else begin
         group_of = GRP_SIMPLE;
      end
   endfunction
endpackage

// file: src/icache_mem.sv
`timescale 1ns/1ps
module icache_mem import frontend_pkg::*; (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic rd_en,
   input wire logic [XLEN-1:0] rd_addr,
   input wire logic wr_en,
   input wire logic [XLEN-1:0] wr_addr,
   input wire logic [XLEN-1:0] wr_data,
   output logic rd_hit,
   output logic [XLEN-1:0] rd_data
);
   // ==========================================================
   // direct-mapped arrays
   logic [XLEN-1:0] data_mem [CACHE_WORDS];
   logic [TAG_W-1:0] tag_mem [CACHE_WORDS];
   logic [CACHE_WORDS-1:0] valid_reg;
   logic hit_reg;
   logic [XLEN-1:0] data_reg;
   logic [IDX_W-1:0] wr_idx;
   logic [IDX_W-1:0] rd_idx;

   assign wr_idx = wr_addr[TAG_LSB-1:IDX_LSB];
   assign rd_idx = rd_addr[TAG_LSB-1:IDX_LSB];
   assign rd_hit = hit_reg;
   assign rd_data = data_reg;

   // line fill, no reset on the arrays
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         data_mem[wr_idx] <= wr_data;
         tag_mem[wr_idx] <= wr_addr[XLEN-1:TAG_LSB];
      end
   end

   // valid bits cleared at reset
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         valid_reg <= '0;
      end else if (wr_en) begin
         valid_reg[wr_idx] <= 1'b1;
      end
   end

   // registered lookup, held until next read
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         hit_reg <= 1'b0;
         data_reg <= '0;
      end else if (rd_en) begin
         hit_reg <= valid_reg[rd_idx] &&
            (tag_mem[rd_idx] == rd_addr[XLEN-1:TAG_LSB]);
         data_reg <= data_mem[rd_idx];
      end
   end
endmodule // icache_mem

// file: src/ea_unit.sv
`timescale 1ns/1ps
module ea_unit import frontend_pkg::*; (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic req,
   input wire logic consume,
   input wire logic [XLEN-1:0] word,
   input wire logic [XLEN-1:0] ip,
   output logic done,
   output logic [XLEN-1:0] ea
);
   // ==========================================================
   // latency from address mode, capped
   logic [2:0] cnt_reg;
   logic [2:0] lat;
   logic [XLEN-1:0] ofs;

   assign lat = (word[LAT_MSB:LAT_LSB] > EA_MAX_CYC) ? EA_MAX_CYC :
      word[LAT_MSB:LAT_LSB];
   assign done = req && (cnt_reg >= lat);
   assign ofs = {{(XLEN-OFS_W){1'b0}}, word[OFS_MSB:0]};
   assign ea = word[EA_IPREL_BIT] ? (ip + ofs) : ofs;

   // cycle counter, restarts per instruction
   always_ff @(posedge core_clk) begin
      if (!rstn || !req || consume) begin
         cnt_reg <= 3'h0;
      end else if (!done) begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end

   // ==========================================================
   // checks
   ea_bound_a: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(req) |-> ##[0:4] done)
      else $error("address calculation exceeded four cycles");
endmodule // ea_unit

// file: src/instruction_fetch_decode_frontend.sv
`timescale 1ns/1ps
// Contract
// - 512-byte direct-mapped instruction cache feeds decoder
// - look ahead; prefetch request on miss
// - returned instruction written into cache
// - decoder notifies fetch of resolved branches
// - notified fetch checks cache, fetches new path
// - immediate need forwards fetched word directly
// - per-stage pointers saved when a fault occurs
// - four groups: simple, float/branch, complex, ldst
// - simple instructions go to integer unit
// - float instructions go to float unit
// - decoder executes branches, no other unit
// - condition-code writer marks scoreboard pending
// - pending scoreboard stalls conditional branch
// - clear scoreboard lets branch redirect immediately
// - true conditional fault raises fault, handler call
// - branch adds no cycles behind long work
// - complex instructions go to microcode sequencer
// - loads and stores go to bus logic
// - address calculation takes zero to four cycles
module instruction_fetch_decode_frontend import frontend_pkg::*; (
   input wire logic core_clk,
   input wire logic rstn,
   output logic pf_req_valid,
   output logic [XLEN-1:0] pf_req_addr,
   input wire logic pf_req_ready,
   input wire logic pf_rsp_valid,
   input wire logic [XLEN-1:0] pf_rsp_data,
   output logic int_valid,
   output logic float_valid,
   output logic seq_valid,
   output logic mem_valid,
   input wire logic int_ready,
   input wire logic float_ready,
   input wire logic seq_ready,
   input wire logic mem_ready,
   output logic [XLEN-1:0] disp_word,
   output logic [XLEN-1:0] disp_ip,
   output logic [XLEN-1:0] disp_ea,
   input wire logic cc_mark,
   input wire logic cc_write,
   input wire logic [COND_W-1:0] cc_value,
   input wire logic unit_fault,
   output logic fault_event,
   output logic handler_call,
   output logic [COND_W-1:0] handler_num,
   output logic [XLEN-1:0] saved_fetch_ip,
   output logic [XLEN-1:0] saved_decode_ip,
   output logic [XLEN-1:0] saved_exec_ip
);
   // ==========================================================
   // fetch_unit state
   fetch_e state_reg;
   logic [XLEN-1:0] look_ip_reg;
   logic [XLEN-1:0] miss_ip_reg;
   logic drop_reg;
   logic out_valid_reg;
   logic [XLEN-1:0] out_word_reg;
   logic [XLEN-1:0] out_ip_reg;
   logic cache_hit;
   logic [XLEN-1:0] cache_data;
   logic rd_en;
   logic wr_en;
   logic take;
   logic out_free;
   logic load_hit;
   logic load_fwd;

   // instruction_decoder state
   logic dec_valid_reg;
   logic [XLEN-1:0] dec_word_reg;
   logic [XLEN-1:0] dec_ip_reg;
   logic dec_done;
   logic dec_free;
   logic redir;
   logic [XLEN-1:0] redir_ip;
   logic cond_true;
   logic cfault_fire;
   logic disp_load;
   kind_e dec_kind;
   group_e dec_grp;
   logic ea_done;
   logic [XLEN-1:0] ea_val;

   // dispatch, scoreboard and fault state
   logic [3:0] unit_sel_reg;
   logic [3:0] ready_vec;
   logic disp_accept;
   logic disp_free;
   logic [XLEN-1:0] disp_word_reg;
   logic [XLEN-1:0] disp_ip_reg;
   logic [XLEN-1:0] disp_ea_reg;
   logic cc_pending_reg;
   logic [COND_W-1:0] cc_reg;
   logic fault_event_reg;
   logic handler_call_reg;
   logic [COND_W-1:0] handler_num_reg;
   logic [XLEN-1:0] sv_fetch_reg;
   logic [XLEN-1:0] sv_decode_reg;
   logic [XLEN-1:0] sv_exec_reg;

   // ==========================================================
   // instruction cache
   assign rd_en = (state_reg == F_PROBE);
   assign wr_en = (state_reg == F_WAIT) && pf_rsp_valid;

   icache_mem u_icache (
      .core_clk(core_clk),
      .rstn(rstn),
      .rd_en(rd_en),
      .rd_addr(look_ip_reg),
      .wr_en(wr_en),
      .wr_addr(miss_ip_reg),
      .wr_data(pf_rsp_data),
      .rd_hit(cache_hit),
      .rd_data(cache_data)
   );

   // ==========================================================
   // fetch_unit handshakes
   assign take = out_valid_reg && dec_free && !redir;
   assign out_free = !out_valid_reg || take;
   assign load_hit = (state_reg == F_CHECK) && cache_hit && out_free;
   assign load_fwd = wr_en && !drop_reg && out_free;
   assign pf_req_valid = (state_reg == F_REQ);
   assign pf_req_addr = miss_ip_reg;

   // lookahead walk, miss and redirect handling
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_reg <= F_PROBE;
         look_ip_reg <= RESET_IP;
         miss_ip_reg <= RESET_IP;
         drop_reg <= 1'b0;
      end else begin
         if (redir) begin
            look_ip_reg <= redir_ip;
         end else if (load_hit || load_fwd) begin
            look_ip_reg <= look_ip_reg + IP_STEP;
         end
         unique case (state_reg)
            F_PROBE: begin
               if (!redir) begin
                  state_reg <= F_CHECK;
               end
            end
            F_CHECK: begin
               if (redir) begin
                  state_reg <= F_PROBE;
               end else if (!cache_hit) begin
                  state_reg <= F_REQ;
                  miss_ip_reg <= look_ip_reg;
               end else if (out_free) begin
                  state_reg <= F_PROBE;
               end
            end
            F_REQ: begin
               if (redir) begin
                  drop_reg <= 1'b1;
               end
               if (pf_req_ready) begin
                  state_reg <= F_WAIT;
               end
            end
            F_WAIT: begin
               if (pf_rsp_valid) begin
                  state_reg <= F_PROBE;
                  drop_reg <= 1'b0;
               end else if (redir) begin
                  drop_reg <= 1'b1;
               end
            end
         endcase
      end
   end

   // word presented to the decoder
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         out_valid_reg <= 1'b0;
         out_word_reg <= '0;
         out_ip_reg <= RESET_IP;
      end else if (redir) begin
         out_valid_reg <= 1'b0;
      end else if (load_hit || load_fwd) begin
         out_valid_reg <= 1'b1;
         out_word_reg <= load_fwd ? pf_rsp_data : cache_data;
         out_ip_reg <= look_ip_reg;
      end else if (take) begin
         out_valid_reg <= 1'b0;
      end
   end

   // ==========================================================
   // instruction_decoder
   assign dec_kind = kind_of(dec_word_reg[OP_MSB:OP_LSB]);
   assign dec_grp = group_of(dec_word_reg[OP_MSB:OP_LSB]);
   assign cond_true = |(dec_word_reg[OP_LSB+COND_W-1:OP_LSB] & cc_reg);
   assign redir_ip = dec_ip_reg + {{(XLEN-DISP_W-DISP_SHIFT){
      dec_word_reg[DISP_MSB]}}, dec_word_reg[DISP_MSB:0],
      {DISP_SHIFT{1'b0}}};
   assign ready_vec = {mem_ready, seq_ready, float_ready, int_ready};
   assign disp_accept = |(unit_sel_reg & ready_vec);
   assign disp_free = (unit_sel_reg == 4'h0) || disp_accept;

   // branch execution and dispatch readiness
   always_comb begin
      redir = 1'b0;
      dec_done = 1'b0;
      cfault_fire = 1'b0;
      if (dec_valid_reg) begin
         unique case (dec_kind)
            KIND_BR: begin
               redir = 1'b1;
               dec_done = 1'b1;
            end
            KIND_CBR: begin
               dec_done = !cc_pending_reg;
               redir = !cc_pending_reg && cond_true;
            end
            KIND_CFLT: begin
               dec_done = !cc_pending_reg;
               cfault_fire = !cc_pending_reg && cond_true;
            end
            KIND_NONE: begin
               dec_done = disp_free &&
                  ((dec_grp != GRP_LDST) || ea_done);
            end
         endcase
      end
   end

   assign dec_free = !dec_valid_reg || dec_done;
   assign disp_load = dec_valid_reg && dec_done && (dec_kind == KIND_NONE);

   ea_unit u_ea (
      .core_clk(core_clk),
      .rstn(rstn),
      .req(dec_valid_reg && (dec_kind == KIND_NONE) &&
         (dec_grp == GRP_LDST)),
      .consume(dec_done),
      .word(dec_word_reg),
      .ip(dec_ip_reg),
      .done(ea_done),
      .ea(ea_val)
   );

   // decode stage register
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         dec_valid_reg <= 1'b0;
         dec_word_reg <= '0;
         dec_ip_reg <= RESET_IP;
      end else if (take) begin
         dec_valid_reg <= 1'b1;
         dec_word_reg <= out_word_reg;
         dec_ip_reg <= out_ip_reg;
      end else if (dec_done) begin
         dec_valid_reg <= 1'b0;
      end
   end

   // ==========================================================
   // dispatch to execution units
   assign int_valid = unit_sel_reg[0];
   assign float_valid = unit_sel_reg[1];
   assign seq_valid = unit_sel_reg[2];
   assign mem_valid = unit_sel_reg[3];
   assign disp_word = disp_word_reg;
   assign disp_ip = disp_ip_reg;
   assign disp_ea = disp_ea_reg;

   // one slot, routed by group
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         unit_sel_reg <= 4'h0;
         disp_word_reg <= '0;
         disp_ip_reg <= RESET_IP;
         disp_ea_reg <= '0;
      end else if (disp_load) begin
         unit_sel_reg <= dec_grp;
         disp_word_reg <= dec_word_reg;
         disp_ip_reg <= dec_ip_reg;
         disp_ea_reg <= ea_val;
      end else if (disp_accept) begin
         unit_sel_reg <= 4'h0;
      end
   end

   // condition-code scoreboard, mark wins over write
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cc_pending_reg <= 1'b0;
         cc_reg <= '0;
      end else begin
         if (cc_mark) begin
            cc_pending_reg <= 1'b1;
         end else if (cc_write) begin
            cc_pending_reg <= 1'b0;
         end
         if (cc_write) begin
            cc_reg <= cc_value;
         end
      end
   end

   // ==========================================================
   // faults and saved pointers
   assign fault_event = fault_event_reg;
   assign handler_call = handler_call_reg;
   assign handler_num = handler_num_reg;
   assign saved_fetch_ip = sv_fetch_reg;
   assign saved_decode_ip = sv_decode_reg;
   assign saved_exec_ip = sv_exec_reg;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         fault_event_reg <= 1'b0;
         handler_call_reg <= 1'b0;
         handler_num_reg <= '0;
         sv_fetch_reg <= RESET_IP;
         sv_decode_reg <= RESET_IP;
         sv_exec_reg <= RESET_IP;
      end else begin
         fault_event_reg <= cfault_fire;
         handler_call_reg <= fault_event_reg;
         if (cfault_fire) begin
            handler_num_reg <= dec_word_reg[OP_LSB+COND_W-1:OP_LSB];
         end
         if (unit_fault || cfault_fire) begin
            sv_fetch_reg <= look_ip_reg;
            sv_decode_reg <= dec_ip_reg;
            sv_exec_reg <= disp_ip_reg;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   miss_prefetch_a: assert property (
      state_reg == F_CHECK && !cache_hit && !redir |=> pf_req_valid)
      else $error("miss did not raise a prefetch request");
   fill_then_hit_a: assert property (
      wr_en && !out_free && !redir ##1 !redir |=> cache_hit)
      else $error("returned word not found in cache");
   bypass_fwd_a: assert property (
      load_fwd && !redir |=> out_valid_reg &&
      out_word_reg == $past(pf_rsp_data))
      else $error("immediate word not forwarded");
   branch_redir_a: assert property (
      dec_valid_reg && dec_kind == KIND_BR |-> dec_done ##1
      (look_ip_reg == $past(redir_ip) && !out_valid_reg))
      else $error("branch did not redirect fetch");
   cc_stall_a: assert property (
      dec_valid_reg && dec_kind == KIND_CBR && cc_pending_reg
      |-> !redir && !dec_done)
      else $error("branch passed a pending scoreboard");
   cc_mark_a: assert property (
      cc_mark |=> cc_pending_reg)
      else $error("scoreboard not pending after mark");
   simple_route_a: assert property (
      disp_load && dec_grp == GRP_SIMPLE |=> int_valid && !mem_valid)
      else $error("simple instruction misrouted");
   ldst_route_a: assert property (
      disp_load && dec_grp == GRP_LDST |=> mem_valid && !int_valid)
      else $error("load or store misrouted");
   cfault_seq_a: assert property (
      cfault_fire |=> fault_event ##1 handler_call)
      else $error("fault event not followed by handler call");
   fault_ptr_a: assert property (
      unit_fault |=> saved_exec_ip == $past(disp_ip_reg) &&
      saved_fetch_ip == $past(look_ip_reg))
      else $error("stage pointers not saved on fault");

   hit_deliver_c: cover property (load_hit ##1 take);
   miss_fwd_c: cover property (pf_req_valid ##[1:20] load_fwd);
   cc_wait_c: cover property (
      dec_kind == KIND_CBR && cc_pending_reg ##1 redir);
   cfault_c: cover property (cfault_fire);
endmodule // instruction_fetch_decode_frontend

// file: verif/prefetch_mem_model.sv
`timescale 1ns/1ps
// =============================================================
// memory and bus side answering prefetch requests
module prefetch_mem_model import frontend_pkg::*; (
   input wire logic core_clk,
   input wire logic pf_req_valid,
   input wire logic [XLEN-1:0] pf_req_addr,
   output logic pf_req_ready,
   output logic pf_rsp_valid,
   output logic [XLEN-1:0] pf_rsp_data
);
   logic [XLEN-1:0] mem [0:63];
   logic [XLEN-1:0] last;

   // one request at a time, random accept and answer delays
   initial begin
      pf_req_ready = 1'b0;
      pf_rsp_valid = 1'b0;
      pf_rsp_data = 32'h0000_0000;
      last = 32'h0000_0000;
      forever begin
         @(posedge core_clk);
         #1;
         pf_rsp_valid = 1'b0;
         pf_rsp_data = ~last; // stale word never lingers on the lines
         if (pf_req_valid) begin
            repeat ($urandom_range(2)) @(posedge core_clk);
            #1 pf_req_ready = 1'b1;
            @(posedge core_clk);
            last = mem[pf_req_addr[7:2]]; // one word per request
            #1 pf_req_ready = 1'b0;
            repeat ($urandom_range(2)) @(posedge core_clk);
            #1 pf_rsp_valid = 1'b1;
            pf_rsp_data = last;
         end
      end
   end
endmodule // prefetch_mem_model

// file: verif/instruction_fetch_decode_frontend_tb.sv
`timescale 1ns/1ps
module instruction_fetch_decode_frontend_tb;
   import frontend_pkg::*;
   logic core_clk, rstn, cc_mark, cc_write, unit_fault;
   logic fe_d = 1'b0;
   logic hold = 1'b0;
   logic pf_req_valid, pf_req_ready, pf_rsp_valid;
   logic [XLEN-1:0] pf_req_addr, pf_rsp_data, disp_word, disp_ip, disp_ea;
   logic [XLEN-1:0] saved_fetch_ip, saved_decode_ip, saved_exec_ip;
   logic [XLEN-1:0] prev_word;
   logic [XLEN-1:0] prog [0:63];
   logic [3:0] vld, rdy;
   logic [COND_W-1:0] cc_value, handler_num;
   logic fault_event, handler_call;
   int error_cnt = 0, n_checks = 0, n_disp = 0, fault_cnt = 0;
   int exp_q[$];

   // =============================================================
   // clock, design and partner
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   instruction_fetch_decode_frontend u_dut (.core_clk(core_clk),
      .rstn(rstn), .pf_req_valid(pf_req_valid), .pf_req_addr(pf_req_addr),
      .pf_req_ready(pf_req_ready), .pf_rsp_valid(pf_rsp_valid),
      .pf_rsp_data(pf_rsp_data), .int_valid(vld[3]), .float_valid(vld[2]),
      .seq_valid(vld[1]), .mem_valid(vld[0]), .int_ready(rdy[3]),
      .float_ready(rdy[2]), .seq_ready(rdy[1]), .mem_ready(rdy[0]),
      .disp_word(disp_word), .disp_ip(disp_ip), .disp_ea(disp_ea),
      .cc_mark(cc_mark), .cc_write(cc_write), .cc_value(cc_value),
      .unit_fault(unit_fault), .fault_event(fault_event),
      .handler_call(handler_call), .handler_num(handler_num),
      .saved_fetch_ip(saved_fetch_ip), .saved_decode_ip(saved_decode_ip),
      .saved_exec_ip(saved_exec_ip));

   prefetch_mem_model u_mem (.core_clk(core_clk),
      .pf_req_valid(pf_req_valid), .pf_req_addr(pf_req_addr),
      .pf_req_ready(pf_req_ready), .pf_rsp_valid(pf_rsp_valid),
      .pf_rsp_data(pf_rsp_data));

   // =============================================================
   // expectation helpers
   function automatic logic [3:0] exp_unit(input logic [XLEN-1:0] w);
      case (w[31:28])
         4'h6: exp_unit = 4'h2;
         4'h7: exp_unit = 4'h4;
         4'h8, 4'h9, 4'hA, 4'hB, 4'hC: exp_unit = 4'h1;
         default: exp_unit = 4'h8;
      endcase
   endfunction

   function automatic logic [XLEN-1:0] exp_ea(input logic [XLEN-1:0] w,
         input logic [XLEN-1:0] ip);
      exp_ea = {20'h0_0000, w[11:0]} + (w[15] ? ip : 32'h0000_0000);
   endfunction

   function automatic logic [XLEN-1:0] rand_op();
      logic [7:0] op;
      case ($urandom_range(3))
         0: op = {4'(2 + $urandom_range(3)), 4'($urandom)};
         1: op = {4'h6, 4'($urandom)};
         2: op = {4'h7, 4'($urandom)};
         default: op = {4'(8 + $urandom_range(4)), 4'($urandom)};
      endcase
      rand_op = {op, 24'($urandom)};
   endfunction

   task automatic chk(input string what, input logic [XLEN-1:0] exp,
         input logic [XLEN-1:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wait_disp(input int n);
      int k;
      k = 0;
      while (n_disp < n && k < 3000) begin
         @(posedge core_clk);
         k++;
      end
      #1;
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // =============================================================
   // dispatch and fault monitor
   always @(posedge core_clk) begin
      if (rstn) begin
         if (hold) chk("held word", prev_word, disp_word);
         if (|(vld & rdy)) begin
            if (exp_q.size() == 0) begin
               chk("extra dispatch", 32'h0, XLEN'(n_disp + 1));
            end else begin
               chk("ip", XLEN'(exp_q[0] * 4), disp_ip);
               chk("word", prog[exp_q[0]], disp_word);
               chk("unit", XLEN'(exp_unit(disp_word)), XLEN'(vld));
               if (vld[0]) chk("ea", exp_ea(disp_word, disp_ip), disp_ea);
               void'(exp_q.pop_front());
            end
            n_disp++;
         end
         if (fault_event) begin
            fault_cnt++;
            chk("fault ip", 32'h0000_0034, saved_decode_ip);
            chk("fault fetch ip", 32'h0000_003C, saved_fetch_ip);
            chk("fault exec ip", 32'h0000_0024, saved_exec_ip);
         end
         if (fe_d) begin
            chk("handler call", 32'h1, XLEN'(handler_call));
            chk("handler num", 32'h1, XLEN'(handler_num));
         end
      end
      fe_d = fault_event;
      hold = |vld && !(|(vld & rdy));
      prev_word = disp_word;
   end

   // random readies, mostly accepting for back to back dispatch
   initial begin
      rdy = 4'h0;
      forever begin
         @(posedge core_clk);
         #1 rdy = 4'($urandom) | 4'($urandom);
      end
   end

   // watchdog
   initial begin
      #(40 * 20000);
      error_cnt++;
      stop_test();
   end

   // =============================================================
   // main sequence
   initial begin
      void'($urandom(46));
      rstn = 1'b0;
      cc_mark = 1'b0;
      cc_write = 1'b0;
      cc_value = 3'h0;
      unit_fault = 1'b0;
      for (int i = 0; i < 64; i++) prog[i] = 32'h0800_0000;
      for (int i = 0; i < 30; i++) prog[i] = rand_op();
      prog[10] = 32'h0800_0003; // jump over two words
      prog[13] = 32'h1900_0000; // conditional fault, mask 1
      prog[14] = 32'h1200_0006; // conditional branch, mask 2
      for (int i = 0; i < 10; i++) exp_q.push_back(i);
      for (int i = 20; i < 30; i++) exp_q.push_back(i);
      for (int i = 0; i < 64; i++) u_mem.mem[i] = prog[i];
      repeat (16) @(posedge core_clk);
      #1 rstn = 1'b1;
      // load cc, then mark it pending behind the fault
      @(posedge core_clk);
      #1 cc_write = 1'b1;
      cc_value = 3'h1;
      @(posedge core_clk);
      #1 cc_write = 1'b0;
      cc_mark = 1'b1;
      @(posedge core_clk);
      #1 cc_mark = 1'b0;
      wait_disp(10);
      repeat (30) @(posedge core_clk);
      chk("stalled count", 32'd10, XLEN'(n_disp));
      chk("early fault", 32'd0, XLEN'(fault_cnt));
      // release the fault, then hold the branch behind a new mark
      #1 cc_write = 1'b1;
      cc_value = 3'h3;
      @(posedge core_clk);
      #1 cc_write = 1'b0;
      cc_mark = 1'b1;
      @(posedge core_clk);
      #1 cc_mark = 1'b0;
      repeat (20) @(posedge core_clk);
      #1 chk("branch stalled", 32'd10, XLEN'(n_disp));
      chk("fault taken", 32'd1, XLEN'(fault_cnt));
      cc_write = 1'b1;
      @(posedge core_clk);
      #1 cc_write = 1'b0;
      wait_disp(20);
      repeat (20) @(posedge core_clk);
      chk("fault count", 32'd1, XLEN'(fault_cnt));
      chk("left over", 32'd0, XLEN'(exp_q.size()));
      #1 unit_fault = 1'b1;
      @(posedge core_clk);
      #1 unit_fault = 1'b0;
      @(posedge core_clk);
      #1 chk("exec ip", 32'h0000_0074, saved_exec_ip);
      chk("decode ip", 32'h0000_0078, saved_decode_ip);
      stop_test();
   end
endmodule // instruction_fetch_decode_frontend_tb
